// ### shared/cfg_bank_pkg.sv
// Shared constants for the system configuration register bank
package cfg_bank_pkg;
  localparam logic [7:0]  WDOG_KEY_ADDR    = 8'hc0;
  localparam logic [7:0]  PULSE_MEM_ADDR   = 8'hc1;
  localparam logic [7:0]  PORT_CTRL_ADDR   = 8'hc2;
  localparam logic [7:0]  LINK_CFG_ADDR    = 8'hc3;
  localparam logic [7:0]  IRQ_ERR_ADDR     = 8'hc4;
  localparam logic [7:0]  MISC_STATUS_ADDR = 8'hea;
  localparam logic [31:0] WDOG_KEY_RESET   = 32'haf0a7435;
  localparam logic [31:0] WDOG_OFF_KEY     = 32'h48dba399;
  localparam logic [31:0] PULSE_MEM_RESET  = 32'h00000001;
  localparam logic [31:0] PULSE_MEM_MASK   = 32'h003ff7ff;
  localparam logic [31:0] PORT_CTRL_RESET  = 32'h41111111;
  localparam logic [31:0] PORT_CTRL_MASK   = 32'hcfffffff;
  localparam logic [31:0] LINK_CFG_RESET   = 32'h10216600;
  localparam logic [31:0] IRQ_ERR_RESET    = 32'h00ff0000;
  localparam logic [31:0] IRQ_ERR_MASK     = 32'hfdfff7ff;
  localparam int PUL_WIDTH_LSB = 0;
  localparam int PUL_EN_BIT    = 8;
  localparam int PUL_FMT_BIT   = 9;
  localparam int PUL_UPD_BIT   = 10;
  localparam int MEM_MODE_LSB  = 12;
  localparam int MEM_ADDR_LSB  = 14;
  localparam int MEM_PU_BIT    = 21;
  localparam int PORT_STRIDE   = 4;
  localparam int PORT_DIR_LSB  = 0;
  localparam int PORT_SEL_LSB  = 2;
  localparam int PIN_CFG_LSB   = 30;
  localparam logic [1:0] DIR_OUTPUT   = 2'h0;
  localparam logic [1:0] DIR_PULLUP   = 2'h1;
  localparam logic [1:0] DIR_PULLDOWN = 2'h2;
  localparam logic [1:0] MEM_OFF      = 2'h0;
  localparam logic [1:0] MEM_PORTS01  = 2'h1;
  localparam logic [1:0] MEM_PORTS23  = 2'h2;
  localparam int LNK_POLY_LSB  = 16;
  localparam int LNK_ORDER_BIT = 15;
  localparam int LNK_START_BIT = 14;
  localparam int LNK_MODE_BIT  = 13;
  localparam int LNK_WAKE_BIT  = 12;
  localparam int LNK_RATE_LSB  = 10;
  localparam int LNK_HRM_BIT   = 9;
  localparam int LNK_CLR_BIT   = 8;
  localparam int LNK_MADR_LSB  = 4;
  localparam int LNK_MLEN_LSB  = 0;
  localparam logic [15:0] CHECK_START_ZERO = 16'h0000;
  localparam logic [15:0] CHECK_START_ONES = 16'h1111;
  localparam logic [15:0] CHECK_POLY_DEF   = 16'h1021;
  localparam int IEH_BOOTCS_BIT = 31;
  localparam int IEH_GPT_LSB    = 28;
  localparam int IEH_GPH_BIT    = 26;
  localparam int IEH_PP_BIT     = 24;
  localparam int IEH_IRQ_LSB    = 16;
  localparam int IEH_ERRH_LSB   = 12;
  localparam int IEH_ERRL_LSB   = 0;
  localparam real CLOCK_MHZ   = 125.0;
  localparam real LP_TICK_US  = 976.5625;
  localparam real STD_TICK_US = 1000.0;
  localparam real SECOND_US   = 1000000.0;
  localparam int  LP_TICK_CYC  = $rtoi(LP_TICK_US * CLOCK_MHZ);
  localparam int  STD_TICK_CYC = $rtoi(STD_TICK_US * CLOCK_MHZ);
  localparam int  SECOND_CYC   = $rtoi(SECOND_US * CLOCK_MHZ);
  localparam int  HOUR_SECONDS = 3600;
  localparam logic [5:0] GPT_HOURS [8] = '{6'd1, 6'd2, 6'd4, 6'd6,
                                           6'd8, 6'd12, 6'd24, 6'd48};
endpackage : cfg_bank_pkg

// ### hw/cfg_bank.sv
// System configuration register bank with port muxing and pulse shaper
`timescale 1ns/1ns
module cfg_bank
  import cfg_bank_pkg::*;
#(
  parameter int PORTS          = 7,
  parameter int LP_TICK_CYCLES = LP_TICK_CYC,
  parameter int STD_TICK_CYCLES = STD_TICK_CYC,
  parameter int SECOND_CYCLES  = SECOND_CYC,
  parameter int HOUR_SECS      = HOUR_SECONDS
)
(
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic      [31:0]  reg_rdata,
  output logic              watchdog_disabled,
  input  wire logic         link_is_spi,
  input  wire logic         flow_meter_mode,
  input  wire logic         low_power_timebase,
  input  wire logic         flow_pulse_req,
  input  wire logic         flow_pulse_down,
  input  wire logic         pulse_update_cmd,
  input  wire logic         tof_trigger,
  input  wire logic [6:0]   gpo,
  input  wire logic         low_speed_clock,
  input  wire logic         fire_burst,
  input  wire logic         us_direction,
  input  wire logic         device_busy,
  input  wire logic         meas_busy,
  input  wire logic         fire_busy,
  input  wire logic         rx_busy,
  input  wire logic         mem_clock_out,
  input  wire logic         mem_data_out,
  output logic [6:0]        port_out,
  output logic [6:0]        port_oe,
  output logic [6:0]        port_pullup,
  output logic [6:0]        port_pulldown,
  output logic              clock_pin_pullup,
  output logic              clock_pin_pulldown,
  output logic [6:0]        mem_if_target_address,
  input  wire logic         remote_crc_mode,
  input  wire logic         link_irq_event,
  input  wire logic         link_irq_host_clear,
  input  wire logic         link_message_sent,
  output logic              link_irq,
  output logic [15:0]       link_check_polynomial,
  output logic              link_check_reversed,
  output logic [15:0]       link_check_start_value,
  output logic              link_wakeup_enable,
  output logic [1:0]        link_high_rate_select,
  output logic              link_high_rate_mode,
  output logic [7:0]        auto_message_start_address,
  output logic [3:0]        auto_message_length,
  output logic              auto_message_enable,
  input  wire logic [7:0]   irq_sources,
  input  wire logic [14:0]  err_sources,
  output logic              irq_request,
  output logic              error_flag,
  output logic              post_boot_checksum_enable,
  output logic              postprocess_request_enable,
  output logic              housekeeping_request
);

  typedef struct packed {
    logic [31:0] wkey;
    logic [31:0] pmem;
    logic [31:0] port;
    logic [31:0] link;
    logic [31:0] ieh;
    logic [31:0] rdata;
    logic        wd_off;
    logic [7:0]  act_width;
    logic        act_en;
    logic        act_fmt;
    logic        pbusy;
    logic        pdown;
    logic [16:0] tick;
    logic [7:0]  units;
    logic [26:0] sec;
    logic [17:0] hks;
    logic        hk_req;
    logic [6:0]  pout;
    logic [6:0]  poe;
    logic [6:0]  ppu;
    logic [6:0]  ppd;
    logic        irq;
    logic        err;
    logic        lirq;
    logic [15:0] poly;
    logic        rev;
    logic [15:0] start;
    logic        cpu;
    logic        cpd;
    logic        amen;
  } state_t;

  state_t      st;
  state_t      nx;
  logic        pulse_line;
  logic        dir_line;
  logic [1:0]  mem_mode;
  logic [6:0]  mem_clk_pin;
  logic [6:0]  mem_dat_pin;
  logic [3:0]  src [PORTS];
  logic [6:0]  out_d;
  logic [6:0]  oe_d;
  logic [6:0]  pu_d;
  logic [6:0]  pd_d;

  // Per-direction format puts downstream pulses on the direction line
  assign pulse_line = st.pbusy && (!st.act_fmt || !st.pdown);
  assign dir_line   = st.act_fmt ? (st.pbusy && st.pdown) : st.pdown;

  // Ports 2/3 carry SPI lines when link_is_spi is set, so the memory interface may use them only while it is clear
  assign mem_mode    = st.pmem[MEM_MODE_LSB +: 2];
  assign mem_clk_pin = (mem_mode == MEM_PORTS01) ? 7'h01 :
                       (mem_mode == MEM_PORTS23 && !link_is_spi) ? 7'h04 :
                       (mem_mode == MEM_OFF) ? 7'h00 :
                       (mem_mode == MEM_PORTS23) ? 7'h00 : 7'h20;
  assign mem_dat_pin = mem_clk_pin << 1;

  // Source order per port: {code 11, code 10, code 01, code 00}
  assign src[0] = {fire_burst, low_speed_clock, pulse_line, gpo[0]};
  assign src[1] = {us_direction, !st.err, dir_line, gpo[1]};
  assign src[2] = {low_speed_clock, device_busy, pulse_line, gpo[2]};
  assign src[3] = {!st.err, device_busy, dir_line, gpo[3]};
  assign src[4] = {fire_busy, device_busy, meas_busy, gpo[4]};
  assign src[5] = {meas_busy, low_speed_clock, pulse_line, gpo[5]};
  assign src[6] = {rx_busy, !st.err, dir_line, gpo[6]};

  for (genvar n = 0; n < PORTS; n++)
  begin : g_port
    logic [1:0] dir;
    logic [1:0] sel;
    logic       spi_pin;
    logic       mem_pin;
    assign dir     = st.port[PORT_STRIDE*n + PORT_DIR_LSB +: 2];
    assign sel     = st.port[PORT_STRIDE*n + PORT_SEL_LSB +: 2];
    assign spi_pin = link_is_spi && (n == 2 || n == 3);
    assign mem_pin = mem_clk_pin[n] || mem_dat_pin[n];
    // Memory lines are open drain: drive low only, pull-up does the high
    assign out_d[n] = mem_pin ? 1'b0 : src[n][sel];
    assign oe_d[n]  = mem_clk_pin[n] ? !mem_clock_out :
                      mem_dat_pin[n] ? !mem_data_out :
                      (dir == DIR_OUTPUT) && !spi_pin;
    assign pu_d[n]  = mem_pin ? st.pmem[MEM_PU_BIT] :
                      (dir == DIR_PULLUP);
    assign pd_d[n]  = !mem_pin && (dir == DIR_PULLDOWN);
  end

  always_comb
  begin
    logic        upd;
    logic        use_cfg;
    int          tick_lim;
    int          hk_lim;
    nx       = st;
    upd      = 1'b0;
    use_cfg  = 1'b0;
    tick_lim = 0;
    hk_lim   = 0;
    nx.rdata  = '0;
    nx.hk_req = 1'b0;
    if (reg_write)
    begin
      case (reg_addr)
        WDOG_KEY_ADDR:  nx.wkey = reg_wdata;
        PULSE_MEM_ADDR: nx.pmem = reg_wdata & PULSE_MEM_MASK;
        PORT_CTRL_ADDR: nx.port = reg_wdata & PORT_CTRL_MASK;
        LINK_CFG_ADDR:  nx.link = reg_wdata;
        IRQ_ERR_ADDR:   nx.ieh  = reg_wdata & IRQ_ERR_MASK;
        default:        nx.wkey = st.wkey;
      endcase
    end
    if (reg_read)
    begin
      // The key register is write-only and reads as zero
      case (reg_addr)
        PULSE_MEM_ADDR:   nx.rdata = st.pmem;
        PORT_CTRL_ADDR:   nx.rdata = st.port;
        LINK_CFG_ADDR:    nx.rdata = st.link;
        IRQ_ERR_ADDR:     nx.rdata = st.ieh;
        MISC_STATUS_ADDR: nx.rdata = {31'h0, st.wd_off};
        default:          nx.rdata = '0;
      endcase
    end
    nx.wd_off = (st.wkey == WDOG_OFF_KEY);
    // Decoded from the next register value so they move with the register
    nx.cpu  = nx.port[PIN_CFG_LSB +: 2] == DIR_PULLUP;
    nx.cpd  = nx.port[PIN_CFG_LSB +: 2] == DIR_PULLDOWN;
    nx.amen = nx.link[LNK_MLEN_LSB +: 4] != 4'h0;

    // Pulse settings go live only at the chosen update point
    upd = st.pmem[PUL_UPD_BIT] ? tof_trigger : pulse_update_cmd;
    if (upd)
    begin
      nx.act_width = st.pmem[PUL_WIDTH_LSB +: 8];
      nx.act_en    = st.pmem[PUL_EN_BIT] && flow_meter_mode;
      nx.act_fmt   = st.pmem[PUL_FMT_BIT];
    end
    tick_lim = low_power_timebase ? LP_TICK_CYCLES : STD_TICK_CYCLES;
    if (st.pbusy)
    begin
      // Requests during a running pulse are dropped, not queued
      if (st.tick == 17'(tick_lim - 1))
      begin
        nx.tick  = '0;
        nx.units = st.units - 8'h01;
        if (st.units == 8'h01)
          nx.pbusy = 1'b0;
      end
      else
        nx.tick = st.tick + 17'h00001;
    end
    else if (flow_pulse_req && st.act_en && st.act_width != 8'h00)
    begin
      nx.pbusy = 1'b1;
      nx.pdown = flow_pulse_down;
      nx.units = st.act_width;
      nx.tick  = '0;
    end

    nx.pout = out_d;
    nx.poe  = oe_d;
    nx.ppu  = pu_d;
    nx.ppd  = pd_d;

    nx.irq = |(irq_sources & st.ieh[IEH_IRQ_LSB +: 8]);
    nx.err = |(err_sources & {st.ieh[IEH_ERRH_LSB +: 4],
                              st.ieh[IEH_ERRL_LSB +: 11]});

    // A new event beats a clear in the same cycle
    if (link_irq_event)
      nx.lirq = 1'b1;
    else if (st.link[LNK_CLR_BIT] ? link_message_sent
                                  : link_irq_host_clear)
      nx.lirq = 1'b0;

    use_cfg = flow_meter_mode ? st.link[LNK_MODE_BIT]
                              : remote_crc_mode;
    nx.poly  = use_cfg ? st.link[LNK_POLY_LSB +: 16] : CHECK_POLY_DEF;
    nx.rev   = use_cfg && st.link[LNK_ORDER_BIT];
    nx.start = (use_cfg && !st.link[LNK_START_BIT]) ? CHECK_START_ZERO
                                                     : CHECK_START_ONES;

    // Seconds prescaler keeps the hour counter narrow
    hk_lim = int'(GPT_HOURS[st.ieh[IEH_GPT_LSB +: 3]]) * HOUR_SECS;
    if (st.sec == 27'(SECOND_CYCLES - 1))
    begin
      nx.sec = '0;
      if (st.hks >= 18'(hk_lim - 1))
      begin
        nx.hks    = '0;
        nx.hk_req = st.ieh[IEH_GPH_BIT];
      end
      else
        nx.hks = st.hks + 18'h00001;
    end
    else
      nx.sec = st.sec + 27'h0000001;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st           <= '0;
      st.wkey      <= WDOG_KEY_RESET;
      st.pmem      <= PULSE_MEM_RESET;
      st.port      <= PORT_CTRL_RESET;
      st.link      <= LINK_CFG_RESET;
      st.ieh       <= IRQ_ERR_RESET;
      st.act_width <= PULSE_MEM_RESET[PUL_WIDTH_LSB +: 8];
      st.poly      <= CHECK_POLY_DEF;
      st.start     <= CHECK_START_ONES;
      st.cpu       <= PORT_CTRL_RESET[PIN_CFG_LSB +: 2] == DIR_PULLUP;
    end
    else
      st <= nx;
  end

  assign reg_rdata                  = st.rdata;
  assign watchdog_disabled          = st.wd_off;
  assign port_out                   = st.pout;
  assign port_oe                    = st.poe;
  assign port_pullup                = st.ppu;
  assign port_pulldown              = st.ppd;
  assign clock_pin_pullup           = st.cpu;
  assign clock_pin_pulldown         = st.cpd;
  assign mem_if_target_address      = st.pmem[MEM_ADDR_LSB +: 7];
  assign link_irq                   = st.lirq;
  assign link_check_polynomial      = st.poly;
  assign link_check_reversed        = st.rev;
  assign link_check_start_value     = st.start;
  assign link_wakeup_enable         = st.link[LNK_WAKE_BIT];
  assign link_high_rate_select      = st.link[LNK_RATE_LSB +: 2];
  assign link_high_rate_mode        = st.link[LNK_HRM_BIT];
  assign auto_message_start_address = {st.link[LNK_MADR_LSB +: 4], 4'h0};
  assign auto_message_length        = st.link[LNK_MLEN_LSB +: 4];
  assign auto_message_enable        = st.amen;
  assign irq_request                = st.irq;
  assign error_flag                 = st.err;
  assign post_boot_checksum_enable  = st.ieh[IEH_BOOTCS_BIT];
  assign postprocess_request_enable = st.ieh[IEH_PP_BIT];
  assign housekeeping_request       = st.hk_req;

  wdog_off_a: assert property (@(posedge clock) disable iff (reset)
    reg_write && reg_addr == WDOG_KEY_ADDR && reg_wdata == WDOG_OFF_KEY
    |-> ##2 watchdog_disabled)
    else $error("watchdog not disabled by key");

  wdog_on_a: assert property (@(posedge clock) disable iff (reset)
    reg_write && reg_addr == WDOG_KEY_ADDR && reg_wdata != WDOG_OFF_KEY
    |-> ##2 !watchdog_disabled)
    else $error("watchdog disabled by wrong key");

  unused_zero_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && reg_addr == PULSE_MEM_ADDR
    |=> reg_rdata[31:22] == 10'h000 && !reg_rdata[11])
    else $error("unused pulse bits read nonzero");

  mem_addr_a: assert property (@(posedge clock) disable iff (reset)
    reg_write && reg_addr == PULSE_MEM_ADDR
    ##1 !(reg_write && reg_addr == PULSE_MEM_ADDR)
    |=> mem_if_target_address == $past(reg_wdata[MEM_ADDR_LSB +: 7], 2))
    else $error("memory target address not taken");

  spi_hiz_a: assert property (@(posedge clock) disable iff (reset)
    link_is_spi && st.port[9:8] == DIR_OUTPUT && mem_mode != MEM_PORTS01
    |=> !port_oe[2])
    else $error("spi select port driven");

  irq_allow_a: assert property (@(posedge clock) disable iff (reset)
    (irq_sources & st.ieh[IEH_IRQ_LSB +: 8]) != 8'h00 |=> irq_request)
    else $error("enabled interrupt source not requested");

  err_mask_a: assert property (@(posedge clock) disable iff (reset)
    st.ieh[15:12] == 4'h0 && st.ieh[10:0] == 11'h000 |=> !error_flag)
    else $error("masked error raised flag");

  link_irq_set_a: assert property (@(posedge clock) disable iff (reset)
    link_irq_event |=> link_irq)
    else $error("link interrupt event lost");

  link_irq_hold_a: assert property (@(posedge clock) disable iff (reset)
    st.link[LNK_CLR_BIT] && link_irq && !link_irq_event && !link_message_sent
    |=> link_irq)
    else $error("link interrupt cleared without message");

  pulse_hold_a: assert property (@(posedge clock) disable iff (reset)
    !st.pmem[PUL_UPD_BIT] && !pulse_update_cmd && !reset
    |=> $stable(st.act_width) && $stable(st.act_en))
    else $error("pulse settings changed without update");

  hk_gate_a: assert property (@(posedge clock) disable iff (reset)
    housekeeping_request |-> $past(st.ieh[IEH_GPH_BIT]))
    else $error("housekeeping request while disabled");

endmodule : cfg_bank

// ### tb/host_model.sv
// Host-side register bus master for the configuration bank
`timescale 1ns/1ns
module host_model
  import cfg_bank_pkg::*;
(
  input  wire logic        clock,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_write,
  output logic             reg_read
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'h0;
    reg_read  = 1'h0;
  end

  // Fixed-value bits are sent the way a well-behaved host must send them
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] sent);
    sent = d;
    if (a == LINK_CFG_ADDR)
      sent[LNK_POLY_LSB] = 1'h1;
    if (a == IRQ_ERR_ADDR)
    begin
      sent[27] = 1'h0;
      // Post-processing enable bit is always sent clear, so its request stays off
      sent[IEH_PP_BIT] = 1'h0;
    end
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= sent;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
    // Released bus shows a changed pattern, not the last value
    reg_wdata <= ~sent;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    reg_addr <= ~a;
  endtask : rd
endmodule : host_model

// ### tb/tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
module tb
  import cfg_bank_pkg::*;
;
  localparam int SEC = 5;
  localparam int HR  = 2;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  reg_addr, a, irq_sources;
  logic [31:0] reg_wdata, reg_rdata, sent, m;
  logic [31:0] seed = 32'h3a0a;
  logic        reg_write, reg_read, rd_p1;
  logic        link_is_spi, flow_meter_mode, low_power_timebase;
  logic        flow_pulse_req, flow_pulse_down, pulse_update_cmd;
  logic        tof_trigger, low_speed_clock, fire_burst, us_direction;
  logic        device_busy, meas_busy, fire_busy, rx_busy, mem_clock_out;
  logic        mem_data_out, remote_crc_mode, link_irq_event;
  logic        link_irq_host_clear, link_message_sent;
  logic [6:0]  gpo, port_out, port_oe, port_pullup, port_pulldown;
  logic [6:0]  mem_if_target_address;
  logic [14:0] err_sources;
  logic        watchdog_disabled, clock_pin_pullup, clock_pin_pulldown;
  logic        link_irq, link_check_reversed, link_wakeup_enable;
  logic        link_high_rate_mode, auto_message_enable, irq_request;
  logic        error_flag, post_boot_checksum_enable, housekeeping_request;
  logic        postprocess_request_enable;
  logic [15:0] link_check_polynomial, link_check_start_value;
  logic [1:0]  link_high_rate_select;
  logic [7:0]  auto_message_start_address;
  logic [3:0]  auto_message_length;
  logic [31:0] exp_q[$];
  int          fails = 0;
  int          checks_done = 0;
  logic [31:0] lv[3] = '{32'h8005e6a5, 32'h80059cf0, 32'h80052000};
  logic [32:0] le[3] = '{{16'h8005, 1'h1, 16'h1111},
                         {16'h1021, 1'h0, 16'h1111},
                         {16'h8005, 1'h0, 16'h0000}};

  cfg_bank #(
    .LP_TICK_CYCLES  (3),
    .STD_TICK_CYCLES (4),
    .SECOND_CYCLES   (SEC),
    .HOUR_SECS       (HR)
  ) dut (.*);
  host_model host (.*);

  always #4 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] gpv(input logic [1:0] s, input logic [1:0] d);
    gpv = 32'h40000000;
    for (int i = 0; i < 7; i++)
      gpv[i*4 +: 4] = {s, d};
  endfunction : gpv

  // Error flag is kept low in the mux test, so its inverted copy reads 1
  function automatic logic [6:0] mux_exp(input logic [1:0] c);
    case (c)
      2'h0: mux_exp = gpo;
      2'h1: mux_exp = {2'h0, meas_busy, 4'h0};
      2'h2: mux_exp = {1'h1, low_speed_clock, {3{device_busy}}, 1'h1,
                       low_speed_clock};
      default: mux_exp = {rx_busy, meas_busy, fire_busy, 1'h1,
                          low_speed_clock, us_direction, fire_burst};
    endcase
  endfunction : mux_exp

  task automatic chk(input string s, input logic [32:0] e,
                     input logic [32:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : settle

  task automatic rdx(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    host.rd(ad);
  endtask : rdx

  task automatic strobe(input int k);
    @(posedge clock);
    case (k)
      0: pulse_update_cmd <= 1'h1;
      1: tof_trigger <= 1'h1;
      2: flow_pulse_req <= 1'h1;
      3: link_irq_event <= 1'h1;
      4: link_message_sent <= 1'h1;
      default: link_irq_host_clear <= 1'h1;
    endcase
    @(posedge clock);
    {pulse_update_cmd, tof_trigger, flow_pulse_req} <= 3'h0;
    {link_irq_event, link_message_sent, link_irq_host_clear} <= 3'h0;
    #2;
  endtask : strobe

  task automatic pw(input int e, input int p);
    int n;
    n = 0;
    strobe(2);
    repeat (40)
    begin
      n += port_out[p];
      settle(1);
    end
    chk("pulse cycles", e, n);
  endtask : pw

  task automatic hk(input int e);
    int n;
    n = 0;
    while (housekeeping_request !== 1'h1 && n < 1000)
    begin
      settle(1);
      n++;
    end
    settle(1);
    n = 1;
    while (housekeeping_request !== 1'h1 && n < 1000)
    begin
      settle(1);
      n++;
    end
    chk("timer period", e, n);
  endtask : hk

  // Read data stand in the cycle after the read edge only
  always @(posedge clock)
    rd_p1 <= reg_read;
  always @(negedge clock)
    if (rd_p1)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);

  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    finish_test();
  end

  initial
  begin
    {link_is_spi, low_power_timebase, flow_pulse_req, flow_pulse_down} = '0;
    {pulse_update_cmd, tof_trigger, low_speed_clock, fire_burst} = '0;
    {us_direction, device_busy, meas_busy, fire_busy, rx_busy} = '0;
    {remote_crc_mode, link_irq_event, link_irq_host_clear} = '0;
    {link_message_sent, gpo, irq_sources, err_sources} = '0;
    {flow_meter_mode, mem_clock_out, mem_data_out} = 3'h7;
    rd_p1 = 1'h0;
    repeat (8) @(posedge clock);
    reset <= 1'h0;
    settle(2);
    chk("poly", 16'h1021, link_check_polynomial);
    chk("start", 16'h1111, link_check_start_value);
    chk("sck pullup", 1'h1, clock_pin_pullup);
    rdx(WDOG_KEY_ADDR, 32'h0);
    rdx(PULSE_MEM_ADDR, 32'h00000001);
    rdx(PORT_CTRL_ADDR, 32'h41111111);
    rdx(LINK_CFG_ADDR, 32'h10216600);
    rdx(IRQ_ERR_ADDR, 32'h00ff0000);
    rdx(8'hc5, 32'h0);
    $display("test reset done");
    host.wr(WDOG_KEY_ADDR, WDOG_OFF_KEY ^ 32'h1, sent);
    settle(2);
    chk("wd off", 1'h0, watchdog_disabled);
    host.wr(WDOG_KEY_ADDR, WDOG_OFF_KEY, sent);
    settle(2);
    chk("wd off", 1'h1, watchdog_disabled);
    rdx(MISC_STATUS_ADDR, 32'h1);
    rdx(WDOG_KEY_ADDR, 32'h0);
    $display("test watchdog done");
    @(posedge clock);
    {gpo, low_speed_clock, fire_burst, us_direction, device_busy,
     meas_busy, fire_busy, rx_busy} <= 14'(rnd());
    for (int c = 0; c < 4; c++)
    begin
      host.wr(PORT_CTRL_ADDR, gpv(2'(c), 2'h0), sent);
      settle(2);
      chk("port_out", mux_exp(2'(c)), port_out);
      chk("port_oe", 7'h7f, port_oe);
    end
    for (int d = 1; d < 4; d++)
    begin
      host.wr(PORT_CTRL_ADDR, gpv(2'h0, 2'(d)), sent);
      settle(2);
      chk("dir", {7'h0, {7{d == 1}}, {7{d == 2}}},
          {port_oe, port_pullup, port_pulldown});
    end
    @(posedge clock) link_is_spi <= 1'h1;
    host.wr(PORT_CTRL_ADDR, gpv(2'h0, 2'h0), sent);
    settle(2);
    chk("spi oe", 7'h73, port_oe);
    host.wr(PULSE_MEM_ADDR, 32'h00203000, sent);
    @(posedge clock) {link_is_spi, mem_clock_out} <= 2'h0;
    settle(2);
    chk("mem pins", {7'h3f, 7'h60, 2'h0},
        {port_oe, port_pullup, port_out[6:5]});
    $display("test ports done");
    host.wr(PORT_CTRL_ADDR, 32'h41111144, sent);
    host.wr(PULSE_MEM_ADDR, 32'h102, sent);
    flow_pulse_down <= 1'h1;
    strobe(0);
    pw(8, 0);
    host.wr(PULSE_MEM_ADDR, 32'h103, sent);
    strobe(1);
    pw(8, 0);
    host.wr(PULSE_MEM_ADDR, 32'h503, sent);
    low_power_timebase <= 1'h1;
    strobe(1);
    pw(9, 0);
    @(posedge clock) low_power_timebase <= 1'h0;
    host.wr(PULSE_MEM_ADDR, 32'h303, sent);
    strobe(0);
    pw(12, 1);
    pw(0, 0);
    $display("test pulse done");
    for (int i = 0; i < 3; i++)
    begin
      host.wr(LINK_CFG_ADDR, lv[i], sent);
      settle(2);
      chk("check cfg", le[i], {link_check_polynomial, link_check_reversed,
          link_check_start_value});
      chk("link", {sent[12:9], sent[7:4], 4'h0, sent[3:0], |sent[3:0]},
          {link_wakeup_enable, link_high_rate_select, link_high_rate_mode,
           auto_message_start_address, auto_message_length,
           auto_message_enable});
    end
    for (int i = 1; i < 3; i++)
    begin
      @(posedge clock) {flow_meter_mode, remote_crc_mode} <= 2'(i - 1);
      settle(2);
      chk("remote crc", le[i], {link_check_polynomial, link_check_reversed,
          link_check_start_value});
    end
    host.wr(LINK_CFG_ADDR, 32'h80050000, sent);
    strobe(3);
    chk("link_irq", 1'h1, link_irq);
    strobe(4);
    chk("link_irq", 1'h1, link_irq);
    strobe(5);
    chk("link_irq", 1'h0, link_irq);
    host.wr(LINK_CFG_ADDR, 32'h80050100, sent);
    strobe(3);
    strobe(4);
    chk("link_irq", 1'h0, link_irq);
    $display("test link done");
    for (int n = 0; n < 12; n++)
    begin
      a = PULSE_MEM_ADDR + 8'(n % 3);
      m = (a == PULSE_MEM_ADDR) ? PULSE_MEM_MASK :
          (a == PORT_CTRL_ADDR) ? PORT_CTRL_MASK : 32'hffffffff;
      host.wr(a, rnd(), sent);
      settle(1);
      if (a == PULSE_MEM_ADDR)
        chk("mem addr", sent[20:14], mem_if_target_address);
      if (a == PORT_CTRL_ADDR)
        chk("sck pulls", {sent[31:30] == 2'h1, sent[31:30] == 2'h2},
            {clock_pin_pullup, clock_pin_pulldown});
      rdx(a, sent & m);
    end
    for (int n = 0; n < 8; n++)
    begin
      host.wr(IRQ_ERR_ADDR, rnd(), sent);
      @(posedge clock);
      {irq_sources, err_sources} <= 23'(rnd());
      settle(3);
      chk("irq", |(irq_sources & sent[23:16]), irq_request);
      chk("errflag", |(err_sources & {sent[15:12], sent[10:0]}),
          error_flag);
      chk("boot cs", sent[31], post_boot_checksum_enable);
      chk("pp req", sent[24], postprocess_request_enable);
      rdx(IRQ_ERR_ADDR, sent & IRQ_ERR_MASK);
    end
    $display("test random done");
    for (int c = 0; c < 8; c++)
    begin
      host.wr(IRQ_ERR_ADDR, 32'h04000000 | (32'(c) << 28), sent);
      hk(int'(GPT_HOURS[c]) * HR * SEC);
    end
    $display("test timer done");
    settle(4);
    finish_test();
  end
endmodule : tb
